// file: rtl/abp_pkg.sv
package abp_pkg;

	// ---------------------------------------------------------------
	// Widths and positions
	// ---------------------------------------------------------------
	localparam int unsigned ABP_WORD_W    = 12;     // Result and register word width
	localparam int unsigned ABP_CHAN_W    = 3;      // Channel number width
	localparam int unsigned ABP_LOW_W     = 8;      // Low data lines width
	localparam int unsigned ABP_UPPER_W   = 3;      // Upper data lines width
	localparam int unsigned ABP_HIGH_NIB  = 4;      // Upper bits carried in byte mode
	localparam int unsigned ABP_CHAN_POS  = 4;      // Channel field position in high byte
	localparam int unsigned ABP_BIT8_POS  = 8;      // Word bit carried on data bit eight

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [11:0] ABP_WORD_RST  = 12'h000; // Write word after reset
	localparam logic [2:0]  ABP_CHAN_RST  = 3'h0;    // Channel after reset

	// Host strobe sampled through two flops
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic word_mode;
		logic upper_byte_enable;
	} abp_strobe_s;

	// Strobes idle after reset; all-zero would look like a live read
	localparam abp_strobe_s ABP_STROBE_RST = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		word_mode: 1'b0, upper_byte_enable: 1'b0};

	// Result and its source channel
	typedef struct packed {
		logic [2:0]  chan;
		logic [11:0] data;
	} abp_result_s;

	// Written word with its kind of store
	typedef struct packed {
		logic        full;   // Whole word in one access
		logic        upper;  // Upper nibble only
		logic [11:0] data;
	} abp_write_s;

endpackage

// file: rtl/abp_sync.sv
`timescale 1ns/1ns
module abp_sync #(
	parameter int unsigned      WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0   // Idle level of the pins
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;   // First stage, read only by second

	// Two flops against metastability
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// file: rtl/abp_port.sv
`timescale 1ns/1ns
// Function
// - Drive data pins only during qualified access
// - Same pins return results and accept writes
// - Word mode: shared pin is data bit
// - Byte mode: shared pin selects byte
// - Byte select low: low eight bits
// - Byte select high: upper four bits
// - Upper byte read carries channel number
// - Result presented after read strobe falls
// - Word mode upper lines carry bits
module abp_port
	import abp_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	// Host strobes, pins
	input  wire logic                    cs_n,
	input  wire logic                    rd_n,
	input  wire logic                    wr_n,
	input  wire logic                    word_mode,
	// Low data lines, two-way
	input  wire logic [7:0]              low_data_lines_i,
	output logic      [7:0]              low_data_lines_o,
	output logic                         low_data_lines_oe,
	// Data bit eight / upper byte enable, two-way
	input  wire logic                    data_bit_eight_i,
	output logic                         data_bit_eight_o,
	output logic                         data_bit_eight_oe,
	// Upper data lines, two-way
	input  wire logic [2:0]              upper_data_lines_i,
	output logic      [2:0]              upper_data_lines_o,
	output logic                         upper_data_lines_oe,
	// Result from the converter core
	input  wire abp_pkg::abp_result_s    result,
	// Written word toward control and shadow registers
	output abp_pkg::abp_write_s          wr_word,
	output logic                         wr_strobe
);

	// ---------------------------------------------------------------
	// Reset release and input synchronisation
	// ---------------------------------------------------------------
	logic [1:0]  rst_q;          // Reset release chain
	logic        rst_n_s;        // Released reset
	abp_strobe_s strobe_raw;     // Raw pin strobes
	abp_strobe_s strobe_s;       // Synchronised strobes
	logic [11:0] din_s;          // Synchronised data pins

	// Reset asserts at once, releases after two edges
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n_s = rst_q[1];

	// Shared pin doubles as byte select in byte mode
	assign strobe_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, word_mode: word_mode,
		upper_byte_enable: data_bit_eight_i};

	// Reset to idle strobes, so no access is seen while the chain refills
	abp_sync #(.WIDTH(5), .RST_VAL(ABP_STROBE_RST)) u_sync_strobe (
		.clk_sys (clk_sys),
		.rst_n   (rst_n_s),
		.d       (strobe_raw),
		.q       (strobe_s)
	);

	abp_sync #(.WIDTH(12)) u_sync_data (
		.clk_sys (clk_sys),
		.rst_n   (rst_n_s),
		.d       ({upper_data_lines_i, data_bit_eight_i, low_data_lines_i}),
		.q       (din_s)
	);

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	logic rd_act;        // Qualified read in progress
	logic wr_act;        // Qualified write in progress
	logic wr_act_q;      // Previous write state for end detect
	logic upper_sel;     // Byte mode upper half selected

	assign rd_act    = !strobe_s.cs_n && !strobe_s.rd_n;
	assign wr_act    = !strobe_s.cs_n && !strobe_s.wr_n && strobe_s.rd_n;
	assign upper_sel = !strobe_s.word_mode && strobe_s.upper_byte_enable;

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Output word built from result, lanes chosen by mode
	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			low_data_lines_o   <= 8'h00;
			data_bit_eight_o   <= 1'b0;
			upper_data_lines_o <= 3'h0;
		end else if (strobe_s.word_mode) begin
			// Full word in one access
			low_data_lines_o   <= result.data[7:0];
			data_bit_eight_o   <= result.data[ABP_BIT8_POS];
			upper_data_lines_o <= result.data[11:9];
		end else if (upper_sel) begin
			// Upper nibble plus channel tag, bit seven zero
			low_data_lines_o   <= {1'b0, result.chan, result.data[11:8]};
			data_bit_eight_o   <= 1'b0;
			upper_data_lines_o <= 3'h0;
		end else begin
			// Low byte
			low_data_lines_o   <= result.data[7:0];
			data_bit_eight_o   <= 1'b0;
			upper_data_lines_o <= 3'h0;
		end
	end

	// Drivers on only during a qualified read; shared pin stays input in byte mode
	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			low_data_lines_oe   <= 1'b0;
			data_bit_eight_oe   <= 1'b0;
			upper_data_lines_oe <= 1'b0;
		end else begin
			low_data_lines_oe   <= rd_act;
			data_bit_eight_oe   <= rd_act && strobe_s.word_mode;
			upper_data_lines_oe <= rd_act && strobe_s.word_mode;
		end
	end

	// ---------------------------------------------------------------
	// Write path
	// ---------------------------------------------------------------
	logic [11:0] wdata_q;   // Data sampled while strobe low
	logic        wmode_q;   // Word mode at sample
	logic        wupper_q;  // Upper byte at sample

	// Capture data each cycle the write is active; last value is stored
	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			wdata_q  <= ABP_WORD_RST;
			wmode_q  <= 1'b0;
			wupper_q <= 1'b0;
			wr_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			if (wr_act) begin
				wdata_q  <= din_s;
				wmode_q  <= strobe_s.word_mode;
				wupper_q <= upper_sel;
			end
		end
	end

	// Store on rising write strobe, lanes by mode
	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			wr_word   <= '{full: 1'b0, upper: 1'b0, data: ABP_WORD_RST};
			wr_strobe <= 1'b0;
		end else begin
			wr_strobe <= wr_act_q && !wr_act;
			if (wr_act_q && !wr_act) begin
				if (wmode_q) begin
					wr_word <= '{full: 1'b1, upper: 1'b0, data: wdata_q};
				end else if (wupper_q) begin
					// Bits above the nibble are zero by host contract; dropped here
					wr_word <= '{full: 1'b0, upper: 1'b1,
						data: {wdata_q[3:0], wr_word.data[7:0]}};
				end else begin
					wr_word <= '{full: 1'b0, upper: 1'b0,
						data: {wr_word.data[11:8], wdata_q[7:0]}};
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_no_drive_idle;
		@(posedge clk_sys) disable iff (!rst_n_s)
		!$past(rd_act) |-> !low_data_lines_oe && !upper_data_lines_oe;
	endproperty
	a_no_drive_idle: assert property (p_no_drive_idle) else $error("data driven without read");

	property p_drive_on_read;
		@(posedge clk_sys) disable iff (!rst_n_s)
		rd_act |=> low_data_lines_oe;
	endproperty
	a_drive_on_read: assert property (p_drive_on_read) else $error("read not driven");

	property p_bit8_input_byte;
		@(posedge clk_sys) disable iff (!rst_n_s)
		!$past(strobe_s.word_mode) |-> !data_bit_eight_oe;
	endproperty
	a_bit8_input_byte: assert property (p_bit8_input_byte) else $error("shared pin driven in byte mode");

	property p_word_bit8;
		@(posedge clk_sys) disable iff (!rst_n_s)
		strobe_s.word_mode |=> data_bit_eight_o == $past(result.data[8]);
	endproperty
	a_word_bit8: assert property (p_word_bit8) else $error("bit eight wrong");

	property p_low_byte;
		@(posedge clk_sys) disable iff (!rst_n_s)
		// Sampled reset in the antecedent: the edge that releases reset still resets the lanes
		rst_n_s && !strobe_s.word_mode && !upper_sel |=> low_data_lines_o == $past(result.data[7:0]);
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

	property p_high_byte;
		@(posedge clk_sys) disable iff (!rst_n_s)
		upper_sel |=> low_data_lines_o == {1'b0, $past(result.chan), $past(result.data[11:8])};
	endproperty
	a_high_byte: assert property (p_high_byte) else $error("high byte or channel wrong");

	property p_word_upper;
		@(posedge clk_sys) disable iff (!rst_n_s)
		strobe_s.word_mode |=> upper_data_lines_o == $past(result.data[11:9]);
	endproperty
	a_word_upper: assert property (p_word_upper) else $error("upper lines wrong");

	property p_write_store;
		@(posedge clk_sys) disable iff (!rst_n_s)
		wr_act ##1 !wr_act |=> wr_strobe;
	endproperty
	a_write_store: assert property (p_write_store) else $error("write not stored");

	property p_write_word;
		@(posedge clk_sys) disable iff (!rst_n_s)
		wr_strobe && wr_word.full |-> wr_word.data == $past(wdata_q);
	endproperty
	a_write_word: assert property (p_write_word) else $error("word write data wrong");

	c_word_read:  cover property (@(posedge clk_sys) disable iff (!rst_n_s) rd_act && strobe_s.word_mode);
	c_high_read:  cover property (@(posedge clk_sys) disable iff (!rst_n_s) rd_act && upper_sel);
	c_word_write: cover property (@(posedge clk_sys) disable iff (!rst_n_s) wr_strobe && wr_word.full);
	c_high_write: cover property (@(posedge clk_sys) disable iff (!rst_n_s) wr_strobe && wr_word.upper);

endmodule

// file: bench/abp_host.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host model: moves at the falling edge, floats what it releases
// ---------------------------------------------------------------
module abp_host (
	// Clock and resolved bus
	input  wire logic        clk_sys,
	input  wire logic [11:0] bus,
	// Strobes and mode
	output logic             cs_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic             word_mode,
	// Host drive with per-bit enable
	output logic [11:0]      drv,
	output logic [11:0]      drv_oe,
	// Level of undriven lines, flips each cycle
	output logic [11:0]      float_pat
);
	initial begin
		{cs_n, rd_n, wr_n, word_mode} = 4'hf;
		drv = 12'h000;
		drv_oe = 12'h000;
		float_pat = 12'ha5a;
	end
	// Stale data must never pass for fresh data
	always @(negedge clk_sys) float_pat <= ~float_pat;
	// Mode change, then settle; shared pin is driven by the host in byte mode
	task automatic mode(input logic m);
		@(negedge clk_sys);
		word_mode = m;
		drv_oe[8] = ~m;
		repeat (4) @(negedge clk_sys);
	endtask
	// Read: strobes held 4 cycles, bus taken before release
	task automatic rd(input logic sel, output logic [11:0] q);
		@(negedge clk_sys);
		drv[8] = sel;
		{cs_n, rd_n} = 2'b00;
		repeat (4) @(negedge clk_sys);
		q = bus;
		{cs_n, rd_n} = 2'b11;
		repeat (4) @(negedge clk_sys);
	endtask
	// Write: data stable over the strobe and 3 cycles beyond
	task automatic wr(input logic sel, input logic [11:0] d);
		@(negedge clk_sys);
		drv = d;
		drv[8] = word_mode ? d[8] : sel;
		drv_oe = word_mode ? 12'hfff : 12'h1ff;
		{cs_n, wr_n} = 2'b00;
		repeat (4) @(negedge clk_sys);
		{cs_n, wr_n} = 2'b11;
		repeat (3) @(negedge clk_sys);
		drv_oe = {3'h0, ~word_mode, 8'h00};
		@(negedge clk_sys);
	endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
	import abp_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk_sys, reset_n, cs_n, rd_n, wr_n, word_mode;
	logic [11:0] drv, drv_oe, float_pat, hb, bus, q;
	logic [7:0]  lo_o;
	logic [2:0]  up_o;
	logic        lo_oe, b8_o, b8_oe, up_oe, wr_strobe, bad;
	abp_result_s result;
	abp_write_s  wr_word, got_w;
	int          n_mismatch, tests_run, n_wr, n_seen;
	// Bus level from every party's enables
	assign hb  = (drv_oe & drv) | (~drv_oe & float_pat);
	assign bus = {up_oe ? up_o : hb[11:9], b8_oe ? b8_o : hb[8], lo_oe ? lo_o : hb[7:0]};
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	abp_host u_abp_host (.clk_sys(clk_sys), .bus(bus), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.word_mode(word_mode), .drv(drv), .drv_oe(drv_oe), .float_pat(float_pat));
	abp_port u_abp_port (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.word_mode(word_mode), .low_data_lines_i(bus[7:0]), .low_data_lines_o(lo_o),
		.low_data_lines_oe(lo_oe), .data_bit_eight_i(bus[8]), .data_bit_eight_o(b8_o),
		.data_bit_eight_oe(b8_oe), .upper_data_lines_i(bus[11:9]), .upper_data_lines_o(up_o),
		.upper_data_lines_oe(up_oe), .result(result), .wr_word(wr_word), .wr_strobe(wr_strobe));
	// Catch each stored word; a drive clash or drive during a write sticks
	always @(posedge clk_sys) begin
		if (wr_strobe === 1'b1) begin
			got_w <= wr_word;
			n_wr <= n_wr + 1;
		end
		if ((!word_mode && (b8_oe !== 1'b0 || up_oe !== 1'b0)) || (!wr_n && lo_oe !== 1'b0))
			bad <= 1'b1;
	end
	// ---------------------------------------------------------------
	// Compare and closing tasks
	// ---------------------------------------------------------------
	task automatic fail(input string m);
		n_mismatch++;
		$display("Error %0t: %s", $time, m);
	endtask
	task automatic chk_bus(input logic [11:0] g, input logic [11:0] e);
		tests_run++;
		if (g !== e) fail($sformatf("bus %h expected %h", g, e));
	endtask
	task automatic chk_bit(input logic g, input logic e);
		tests_run++;
		if (g !== e) fail("flag differs");
	endtask
	// Stores are counted, so one that lands before the call is not missed
	task automatic chk_wr(input abp_write_s e);
		n_seen++;
		for (int i = 0; i < 12 && n_wr < n_seen; i++) @(negedge clk_sys);
		if (n_wr < n_seen) begin
			fail("no store strobe");
			end_sim();
		end else begin
			tests_run++;
			if (got_w !== e) fail($sformatf("stored %h expected %h", got_w, e));
		end
	endtask
	task automatic end_sim();
		$display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{reset_n, bad, n_mismatch, tests_run, n_wr, n_seen} = '0;
		result = '{3'h5, 12'hb5c};
		repeat (8) @(negedge clk_sys);
		chk_bit(lo_oe | b8_oe | up_oe, 1'b0);
		reset_n = 1'b1;
		// First edges out of reset must not drive the bus
		repeat (3) @(negedge clk_sys);
		chk_bit(lo_oe | b8_oe | up_oe, 1'b0);
		@(negedge clk_sys);
		// Word read, then bus released
		u_abp_host.rd(1'b0, q);
		chk_bus(q, 12'hb5c);
		chk_bit(lo_oe | b8_oe | up_oe, 1'b0);
		$display("Test word read done");
		// Byte reads: low byte, then high byte for every channel
		u_abp_host.mode(1'b0);
		u_abp_host.rd(1'b0, q);
		chk_bus({4'h0, q[7:0]}, 12'h05c);
		for (int ch = 0; ch < 8; ch++) begin
			result.chan = ch[2:0];
			u_abp_host.rd(1'b1, q);
			chk_bus({4'h0, q[7:0]}, {5'h00, ch[2:0], 4'hb});
		end
		$display("Test byte read done");
		// Writes: full word, low byte, upper nibble
		u_abp_host.mode(1'b1);
		u_abp_host.wr(1'b0, 12'h9a7);
		chk_wr('{1'b1, 1'b0, 12'h9a7});
		u_abp_host.mode(1'b0);
		u_abp_host.wr(1'b0, 12'h03c);
		chk_wr('{1'b0, 1'b0, 12'h93c});
		u_abp_host.wr(1'b1, 12'h005);
		chk_wr('{1'b0, 1'b1, 12'h53c});
		chk_bit(bad, 1'b0);
		$display("Test writes done");
		end_sim();
	end
endmodule
